// file: src/ccc_pkg.sv
// package: constants for the calendar counter clock
package ccc_pkg;
	localparam logic [3:0] WR_COUNT_BYTE_FIRST = 4'h0;
	localparam logic [3:0] WR_COUNT_BYTE_LAST  = 4'h3;
	localparam logic [3:0] WR_PRESCALER_A      = 4'h4;
	localparam logic [3:0] WR_PRESCALER_B      = 4'h5;
	localparam logic [3:0] WR_SECONDS          = 4'h6;
	localparam logic [3:0] WR_MINUTES          = 4'h7;
	localparam logic [3:0] WR_HOURS            = 4'h8;
	localparam logic [3:0] WR_DAY_OF_WEEK      = 4'h9;
	localparam logic [3:0] WR_DAY_OF_MONTH     = 4'ha;
	localparam logic [3:0] WR_MONTH            = 4'hb;
	localparam logic [3:0] WR_YEAR             = 4'hc;
	localparam logic [1:0] SRC_AUX             = 2'h0;
	localparam logic [1:0] SRC_SUB             = 2'h1;
	localparam logic [1:0] SRC_CASCADE         = 2'h2;
	localparam logic [1:0] SRC_PS_A            = 2'h3;
	localparam logic [2:0] CAL_A_DIVIDE        = 3'h7;
	localparam logic [2:0] CAL_B_DIVIDE        = 3'h6;
	localparam logic [7:0] RST_COUNT_BYTE      = 8'h00;
	localparam logic [7:0] RST_DAY_MONTH       = 8'h01;
	localparam logic [15:0] RST_YEAR           = 16'h0000;
	localparam logic [14:0] KEEPOUT_START      = 15'h7f80;
	localparam logic [14:0] KEEPOUT_END        = 15'h007f;
	localparam logic [7:0] MAX_SECONDS         = 8'd59;
	localparam logic [7:0] MAX_HOURS           = 8'd23;
	localparam logic [7:0] MAX_DAY_OF_WEEK     = 8'd6;
	localparam logic [7:0] MAX_MONTH           = 8'd12;
	localparam logic [11:0] MAX_YEAR_BIN       = 12'hfff;
endpackage : ccc_pkg

// file: src/ccc_ps_if.sv
// interface: control and count of one prescaler stage
`timescale 1ns/10ps
`default_nettype none
interface ccc_ps_if;
	logic       tick_in;
	logic       halt;
	logic       clr;
	logic       wr;
	logic [7:0] wdata;
	logic [2:0] div;
	logic [7:0] count;
	logic       tick_out;
	modport ps  (input tick_in, halt, clr, wr, wdata, div, output count, tick_out);
	modport ctl (output tick_in, halt, clr, wr, wdata, div, input count, tick_out);
endinterface : ccc_ps_if
`default_nettype wire

// file: src/ccc_prescaler.sv
// module: one 8-bit prescaler stage with selectable divide tap
`timescale 1ns/10ps
`default_nettype none
module ccc_prescaler
	import ccc_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_nrst,
	ccc_ps_if.ps      ps
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] tap_mask;
	logic       adv;

	// divide by two to the power div+1
	assign tap_mask    = 8'((16'h2 << ps.div) - 16'h1); // RULE4
	assign adv         = ps.tick_in && !ps.halt && !ps.clr && !ps.wr; // RULE10
	assign ps.tick_out = adv && (&(cnt_q | ~tap_mask)); // RULE4
	assign ps.count    = cnt_q;

	always_comb begin
		cnt_d = cnt_q;
		if (ps.clr) begin
			cnt_d = RST_COUNT_BYTE;
		end else if (ps.wr) begin
			cnt_d = ps.wdata; // RULE8
		end else if (adv) begin
			cnt_d = cnt_q + 8'h1; // RULE23
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			cnt_q <= RST_COUNT_BYTE;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	a_ps_halt_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE10
		ps.halt && !ps.clr && !ps.wr |=> $stable(cnt_q))
		else $error("prescaler moved while halted");
endmodule : ccc_prescaler
`default_nettype wire

// file: src/ccc_top.sv
// module: calendar and 32-bit counter clock top
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1: calendar select picks calendar or 32-bit counter
// RULE2: calendar to counter clears bytes and prescalers
// RULE3: counter source aux, subsystem or prescaled clock
// RULE4: prescaler taps divide by 2 through 256
// RULE5: prescaler a may feed b, cascade feeds counter
// RULE6: four cascaded bytes, event selects overflow width
// RULE7: interrupt request only when event enable set
// RULE8: bytes and prescalers writable, effect immediate
// RULE9: prescalers independent or cascaded sixteen bit
// RULE10: own halt stops prescaler, a halts cascade
// RULE11: counter halt depends on chosen source path
// RULE12: software reads stopped counts or majority votes
// RULE13: calendar keeps seconds to year, BCD or binary
// RULE14: every fourth year is a leap year
// RULE15: calendar prescalers give 256 then 128 divide
// RULE16: entering calendar clears time, day month one
// RULE17: format change clears time, day month one
// RULE18: software picks format before loading time
// RULE19: calendar ignores source, divide and halt selects
// RULE20: main halt stops calendar and both prescalers
// RULE21: software initialises registers before use
// RULE22: read valid clear around each second update
// RULE23: stages advance per source edge, carry wrap
module ccc_top
	import ccc_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_aux_clk,
	input  wire logic        i_subsystem_clock,
	input  wire logic        i_calendar_select,
	input  wire logic        i_bcd_format_select,
	input  wire logic        i_main_count_halt,
	input  wire logic        i_prescaler_a_halt,
	input  wire logic        i_prescaler_b_halt,
	input  wire logic        i_prescaler_a_source,
	input  wire logic [1:0]  i_prescaler_b_source,
	input  wire logic [2:0]  i_prescaler_a_divide,
	input  wire logic [2:0]  i_prescaler_b_divide,
	input  wire logic [1:0]  i_counter_source_select,
	input  wire logic [1:0]  i_overflow_event_select,
	input  wire logic        i_overflow_event_irq_enable,
	input  wire logic        i_wr_en,
	input  wire logic [3:0]  i_wr_sel,
	input  wire logic [15:0] i_wr_data,
	output logic      [31:0] o_count,
	output logic      [7:0]  o_prescaler_stage_a,
	output logic      [7:0]  o_prescaler_stage_b,
	output logic      [7:0]  o_seconds,
	output logic      [7:0]  o_minutes,
	output logic      [7:0]  o_hours,
	output logic      [7:0]  o_day_of_week,
	output logic      [7:0]  o_day_of_month,
	output logic      [7:0]  o_month,
	output logic      [15:0] o_year,
	output logic             o_overflow_event,
	output logic             o_irq,
	output logic             o_time_read_valid
);
	ccc_ps_if ps_a_if ();
	ccc_ps_if ps_b_if ();
	logic        aux_prev_q, sub_prev_q, cal_prev_q, bcd_prev_q;
	logic        to_counter, to_calendar, fmt_change, clr_cal, clr_ps;
	logic        cascade, cnt_halt, cnt_inc;
	logic [31:0] cnt_q, cnt_d;
	logic [3:0]  ovf;
	logic [4:0]  carry;
	logic [7:0]  sec_q, min_q, hour_q, dow_q, day_q, mon_q;
	logic [7:0]  sec_d, min_d, hour_d, dow_d, day_d, mon_d, mon_bin;
	logic [15:0] year_q, year_d;
	logic        aux_rise, sub_rise, sec_tick, leap;
	logic [14:0] phase;
	logic        evt_q, evt_d, irq_q, irq_d, rdy_q, rdy_d;
	function automatic logic [7:0] fmt(input logic [7:0] v, input logic bcd);
		return bcd ? {4'(v / 8'd10), 4'(v % 8'd10)} : v;
	endfunction : fmt
	function automatic logic [7:0] inc8(input logic [7:0] v, input logic bcd);
		return (bcd && v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h1;
	endfunction : inc8
	function automatic logic [15:0] inc_year(input logic [15:0] y, input logic bcd);
		logic [15:0] r;
		logic        c;
		r = y;
		c = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (c) begin
				c         = (r[i*4+:4] == 4'h9);
				r[i*4+:4] = c ? 4'h0 : r[i*4+:4] + 4'h1;
			end
		end
		return bcd ? r : {4'h0, y[11:0] + 12'h1};
	endfunction : inc_year
	function automatic logic [7:0] days_in(input logic [7:0] m, input logic lp);
		unique case (m)
			8'd2:                     return lp ? 8'd29 : 8'd28;
			8'd4, 8'd6, 8'd9, 8'd11:  return 8'd30;
			default:                  return 8'd31;
		endcase
	endfunction : days_in
	// source edges and mode change detection
	assign aux_rise    = i_aux_clk && !aux_prev_q; // RULE23
	assign sub_rise    = i_subsystem_clock && !sub_prev_q;
	assign to_counter  = !i_calendar_select && cal_prev_q; // RULE2
	assign to_calendar = i_calendar_select && !cal_prev_q; // RULE16
	assign fmt_change  = i_calendar_select && (i_bcd_format_select != bcd_prev_q); // RULE17
	assign clr_cal     = to_calendar || fmt_change;
	assign clr_ps      = to_counter || clr_cal;
	assign cascade     = (i_prescaler_b_source == SRC_CASCADE); // RULE9
	// prescaler steering: calendar mode overrides all selects
	always_comb begin
		ps_a_if.clr   = clr_ps;
		ps_b_if.clr   = clr_ps;
		ps_a_if.wr    = i_wr_en && i_wr_sel == WR_PRESCALER_A; // RULE8
		ps_b_if.wr    = i_wr_en && i_wr_sel == WR_PRESCALER_B; // RULE8
		ps_a_if.wdata = i_wr_data[7:0];
		ps_b_if.wdata = i_wr_data[7:0];
		if (i_calendar_select) begin
			ps_a_if.tick_in = aux_rise; // RULE15 RULE19
			ps_a_if.div     = CAL_A_DIVIDE; // RULE15
			ps_a_if.halt    = i_main_count_halt; // RULE20
			ps_b_if.tick_in = ps_a_if.tick_out; // RULE15
			ps_b_if.div     = CAL_B_DIVIDE; // RULE15
			ps_b_if.halt    = i_main_count_halt; // RULE20
		end else begin
			ps_a_if.tick_in = i_prescaler_a_source ? sub_rise : aux_rise; // RULE3
			ps_a_if.div     = i_prescaler_a_divide; // RULE4
			ps_a_if.halt    = i_prescaler_a_halt; // RULE10
			ps_b_if.div     = i_prescaler_b_divide; // RULE4
			ps_b_if.halt    = i_prescaler_b_halt || (cascade && i_prescaler_a_halt); // RULE10
			unique case (i_prescaler_b_source)
				SRC_AUX:     ps_b_if.tick_in = aux_rise;
				SRC_CASCADE: ps_b_if.tick_in = ps_a_if.tick_out; // RULE5
				default:     ps_b_if.tick_in = sub_rise; // RULE3
			endcase
		end
	end
	ccc_prescaler u_ps_a (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.ps     (ps_a_if.ps)
	);
	ccc_prescaler u_ps_b (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.ps     (ps_b_if.ps)
	);
	// counter source and halt paths
	always_comb begin
		cnt_halt = i_main_count_halt; // RULE11
		unique case (i_counter_source_select)
			SRC_AUX:     cnt_inc = aux_rise; // RULE3
			SRC_SUB:     cnt_inc = sub_rise; // RULE3
			SRC_CASCADE: begin
				cnt_inc  = ps_b_if.tick_out; // RULE5
				cnt_halt = i_main_count_halt || ps_b_if.halt; // RULE11
			end
			SRC_PS_A:    begin
				cnt_inc  = ps_a_if.tick_out; // RULE3
				cnt_halt = i_main_count_halt || i_prescaler_a_halt; // RULE11
			end
		endcase
	end
	assign carry[0] = cnt_inc && !cnt_halt && !i_calendar_select && !to_counter; // RULE1
	// four cascaded byte counters
	generate
		for (genvar g = 0; g < 4; g++) begin : g_byte
			assign ovf[g]     = carry[g] && cnt_q[g*8+:8] == 8'hff; // RULE6
			assign carry[g+1] = ovf[g];
			always_comb begin
				cnt_d[g*8+:8] = cnt_q[g*8+:8];
				if (to_counter) begin
					cnt_d[g*8+:8] = RST_COUNT_BYTE; // RULE2
				end else if (i_wr_en && i_wr_sel == WR_COUNT_BYTE_FIRST + 4'(g)) begin
					cnt_d[g*8+:8] = i_wr_data[7:0]; // RULE8
				end else if (carry[g]) begin
					cnt_d[g*8+:8] = cnt_q[g*8+:8] + 8'h1; // RULE23
				end
			end
		end
	endgenerate
	// event, request and read valid
	assign phase = {ps_b_if.count[6:0], ps_a_if.count};
	always_comb begin
		evt_d = ovf[i_overflow_event_select]; // RULE6
		irq_d = evt_d && i_overflow_event_irq_enable; // RULE7
		rdy_d = i_calendar_select && !clr_ps
			&& phase < KEEPOUT_START && phase > KEEPOUT_END; // RULE22
	end
	// calendar
	assign sec_tick = i_calendar_select && ps_b_if.tick_out && !clr_cal; // RULE15 RULE22
	assign mon_bin  = i_bcd_format_select ? ({4'h0, mon_q[7:4]} * 8'd10 + {4'h0, mon_q[3:0]})
		: mon_q;
	assign leap     = (year_q[1:0] + {i_bcd_format_select && year_q[4], 1'b0}) == 2'b00; // RULE14
	always_comb begin
		sec_d  = sec_q;
		min_d  = min_q;
		hour_d = hour_q;
		dow_d  = dow_q;
		day_d  = day_q;
		mon_d  = mon_q;
		year_d = year_q;
		if (clr_cal) begin
			sec_d  = RST_COUNT_BYTE; // RULE16 RULE17
			min_d  = RST_COUNT_BYTE;
			hour_d = RST_COUNT_BYTE;
			dow_d  = RST_COUNT_BYTE;
			day_d  = RST_DAY_MONTH;
			mon_d  = RST_DAY_MONTH;
			year_d = RST_YEAR;
		end else if (i_wr_en) begin
			unique case (i_wr_sel)
				WR_SECONDS:      sec_d  = i_wr_data[7:0];
				WR_MINUTES:      min_d  = i_wr_data[7:0];
				WR_HOURS:        hour_d = i_wr_data[7:0];
				WR_DAY_OF_WEEK:  dow_d  = i_wr_data[7:0];
				WR_DAY_OF_MONTH: day_d  = i_wr_data[7:0];
				WR_MONTH:        mon_d  = i_wr_data[7:0];
				WR_YEAR:         year_d = i_wr_data;
				default:         sec_d  = sec_q;
			endcase
		end else if (sec_tick) begin
			sec_d = inc8(sec_q, i_bcd_format_select); // RULE13
			if (sec_q == fmt(MAX_SECONDS, i_bcd_format_select)) begin
				sec_d = RST_COUNT_BYTE;
				min_d = inc8(min_q, i_bcd_format_select);
				if (min_q == fmt(MAX_SECONDS, i_bcd_format_select)) begin
					min_d  = RST_COUNT_BYTE;
					hour_d = inc8(hour_q, i_bcd_format_select);
					if (hour_q == fmt(MAX_HOURS, i_bcd_format_select)) begin
						hour_d = RST_COUNT_BYTE;
						dow_d  = (dow_q == MAX_DAY_OF_WEEK) ? RST_COUNT_BYTE : dow_q + 8'h1;
						day_d  = inc8(day_q, i_bcd_format_select);
						if (day_q == fmt(days_in(mon_bin, leap), i_bcd_format_select)) begin
							day_d = RST_DAY_MONTH; // RULE14
							mon_d = inc8(mon_q, i_bcd_format_select);
							if (mon_q == fmt(MAX_MONTH, i_bcd_format_select)) begin
								mon_d  = RST_DAY_MONTH;
								year_d = inc_year(year_q, i_bcd_format_select);
							end
						end
					end
				end
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			aux_prev_q <= 1'b0;
			sub_prev_q <= 1'b0;
			cal_prev_q <= 1'b0;
			bcd_prev_q <= 1'b0;
			cnt_q      <= {4{RST_COUNT_BYTE}};
			evt_q      <= 1'b0;
			irq_q      <= 1'b0;
			rdy_q      <= 1'b0;
			sec_q      <= RST_COUNT_BYTE;
			min_q      <= RST_COUNT_BYTE;
			hour_q     <= RST_COUNT_BYTE;
			dow_q      <= RST_COUNT_BYTE;
			day_q      <= RST_DAY_MONTH;
			mon_q      <= RST_DAY_MONTH;
			year_q     <= RST_YEAR;
		end else begin
			aux_prev_q <= i_aux_clk;
			sub_prev_q <= i_subsystem_clock;
			cal_prev_q <= i_calendar_select;
			bcd_prev_q <= i_bcd_format_select;
			cnt_q      <= cnt_d;
			evt_q      <= evt_d;
			irq_q      <= irq_d;
			rdy_q      <= rdy_d;
			sec_q      <= sec_d;
			min_q      <= min_d;
			hour_q     <= hour_d;
			dow_q      <= dow_d;
			day_q      <= day_d;
			mon_q      <= mon_d;
			year_q     <= year_d;
		end
	end
	assign o_count             = cnt_q;
	assign o_prescaler_stage_a = ps_a_if.count;
	assign o_prescaler_stage_b = ps_b_if.count;
	assign o_seconds           = sec_q;
	assign o_minutes           = min_q;
	assign o_hours             = hour_q;
	assign o_day_of_week       = dow_q;
	assign o_day_of_month      = day_q;
	assign o_month             = mon_q;
	assign o_year              = year_q;
	assign o_overflow_event    = evt_q;
	assign o_irq               = irq_q;
	assign o_time_read_valid   = rdy_q;
	sequence s_last_phase;
		i_calendar_select && !i_main_count_halt && !i_wr_en && !clr_cal && aux_rise
			&& ps_a_if.count == 8'hff && ps_b_if.count[6:0] == 7'h7f;
	endsequence
	sequence s_counter_hold;
		!i_calendar_select && !to_counter && cnt_halt && !i_wr_en;
	endsequence
	a_mode_clear_cnt: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE2
		to_counter |=> cnt_q == 32'h0 && ps_a_if.count == 8'h0 && ps_b_if.count == 8'h0)
		else $error("counter not cleared on leaving calendar");
	a_cal_entry_init: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE16
		to_calendar |=> sec_q == 8'h0 && day_q == 8'h1 && mon_q == 8'h1 && year_q == 16'h0)
		else $error("calendar not initialised on entry");
	a_fmt_change_init: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE17
		fmt_change |=> hour_q == 8'h0 && day_q == 8'h1 && ps_a_if.count == 8'h0)
		else $error("format change did not reset time");
	a_cnt_halt_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE11
		s_counter_hold |=> $stable(cnt_q))
		else $error("counter moved while halted");
	a_irq_gated: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE7
		o_irq |-> o_overflow_event && $past(i_overflow_event_irq_enable))
		else $error("request without enable or event");
	a_ovf_full_wrap: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE6
		o_overflow_event && $past(i_overflow_event_select) == 2'h3 && !$past(i_wr_en)
			|-> cnt_q == 32'h0)
		else $error("32-bit event without full wrap");
	a_cal_halt_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE20
		i_calendar_select && i_main_count_halt && !i_wr_en && !clr_cal
			|=> $stable(sec_q) && $stable(ps_a_if.count) && $stable(ps_b_if.count))
		else $error("calendar moved while halted");
	a_second_tick: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE15
		s_last_phase |=> !$stable(sec_q) ##1 !o_time_read_valid)
		else $error("second not taken at prescaler wrap");
	a_rdy_counter: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE22
		!i_calendar_select |=> !o_time_read_valid)
		else $error("read valid set in counter mode");
endmodule : ccc_top
`default_nettype wire

// file: test/test_ccc_top.sv
// testbench: self-checking bench for the calendar counter clock
`timescale 1ns/10ps
`default_nettype none
module test_ccc_top;
	import ccc_pkg::*;
	logic        i_clk, i_nrst, i_aux_clk, i_subsystem_clock, i_calendar_select;
	logic        i_bcd_format_select, i_main_count_halt, i_prescaler_a_halt;
	logic        i_prescaler_b_halt, i_prescaler_a_source, i_overflow_event_irq_enable;
	logic        i_wr_en;
	logic [1:0]  i_prescaler_b_source, i_counter_source_select, i_overflow_event_select;
	logic [2:0]  i_prescaler_a_divide, i_prescaler_b_divide;
	logic [3:0]  i_wr_sel;
	logic [15:0] i_wr_data, o_year;
	logic [31:0] o_count;
	logic [7:0]  o_prescaler_stage_a, o_prescaler_stage_b, o_seconds, o_minutes;
	logic [7:0]  o_hours, o_day_of_week, o_day_of_month, o_month;
	logic        o_overflow_event, o_irq, o_time_read_valid;
	int          mismatches, samples_checked, cycles, ev_n, irq_n;

	ccc_top ccc_top_inst (.*);

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// event pulse counters and hang guard
	always @(posedge i_clk) begin
		cycles++;
		if (o_overflow_event === 1'b1) ev_n++;
		if (o_irq === 1'b1) irq_n++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : step

	task wr(input logic [3:0] sel, input logic [15:0] d);
		i_wr_en = 1'b1;
		i_wr_sel = sel;
		i_wr_data = d;
		step(1);
		i_wr_en = 1'b0;
		step(1);
	endtask : wr

	task tick(input int n, input logic sub);
		repeat (n) begin
			if (sub) i_subsystem_clock = 1'b1;
			else i_aux_clk = 1'b1;
			step(2);
			i_subsystem_clock = 1'b0;
			i_aux_clk = 1'b0;
			step(2);
		end
	endtask : tick

	task set_count(input logic [31:0] v);
		for (int i = 0; i < 4; i++) wr(4'(i), {8'h00, v[8*i+:8]});
	endtask : set_count

	task set_time(input logic [15:0] y, input logic [7:0] mo, d, h, mi, s);
		wr(WR_YEAR, y);
		wr(WR_MONTH, {8'h00, mo});
		wr(WR_DAY_OF_MONTH, {8'h00, d});
		wr(WR_HOURS, {8'h00, h});
		wr(WR_MINUTES, {8'h00, mi});
		wr(WR_SECONDS, {8'h00, s});
		wr(WR_PRESCALER_A, 16'h00ff);
		wr(WR_PRESCALER_B, 16'h007f);
		tick(1, 1'b0);
	endtask : set_time

	task t_reset;
		chk("count", 32'h0, o_count);
		chk("ps_a", 32'h0, o_prescaler_stage_a);
		chk("day", 32'h1, o_day_of_month);
		chk("month", 32'h1, o_month);
		chk("valid", 32'h0, o_time_read_valid);
		$display("test reset done");
	endtask : t_reset

	task t_events;
		logic [31:0] lo, hi;
		int e0, q0;
		i_counter_source_select = SRC_AUX;
		for (int es = 0; es < 4; es++) begin
			i_overflow_event_select = 2'(es);
			i_overflow_event_irq_enable = 1'(es);
			lo = (es == 0) ? 32'h0 : (32'hffffffff >> (32 - 8 * es));
			hi = 32'hffffffff >> (24 - 8 * es);
			set_count(lo);
			e0 = ev_n;
			tick(1, 1'b0);
			chk("no_event", 32'(e0), 32'(ev_n));
			chk("count", lo + 32'h1, o_count);
			set_count(hi);
			chk("written", hi, o_count);
			e0 = ev_n;
			q0 = irq_n;
			tick(1, 1'b0);
			chk("event", 32'(e0 + 1), 32'(ev_n));
			chk("irq", 32'(q0 + es % 2), 32'(irq_n));
			chk("wrap", hi + 32'h1, o_count);
		end
		i_counter_source_select = SRC_SUB;
		set_count(32'h0000_0010);
		tick(3, 1'b1);
		chk("sub_count", 32'h13, o_count);
		i_main_count_halt = 1'b1;
		tick(3, 1'b1);
		chk("halted", 32'h13, o_count);
		i_main_count_halt = 1'b0;
		$display("test events done");
	endtask : t_events

	task t_prescale;
		i_counter_source_select = SRC_PS_A;
		for (int d = 0; d < 8; d++) begin
			i_prescaler_a_divide = 3'(d);
			wr(WR_PRESCALER_A, 16'h0);
			set_count(32'h0);
			tick(2 ** (d + 1), 1'b0);
			chk("tap_count", 32'h1, o_count);
			chk("ps_a", 32'((2 ** (d + 1)) % 256), o_prescaler_stage_a);
		end
		i_prescaler_a_source = 1'b1;
		i_prescaler_a_divide = 3'h0;
		wr(WR_PRESCALER_A, 16'h0);
		set_count(32'h0);
		tick(2, 1'b1);
		chk("a_sub", 32'h1, o_count);
		i_prescaler_a_source = 1'b0;
		i_prescaler_b_source = 2'h3;
		i_prescaler_b_divide = 3'h1;
		i_counter_source_select = SRC_CASCADE;
		i_prescaler_a_halt = 1'b1;
		wr(WR_PRESCALER_B, 16'h0);
		set_count(32'h0);
		tick(4, 1'b1);
		chk("ps_b_alone", 32'h4, o_prescaler_stage_b);
		chk("b_count", 32'h1, o_count);
		i_prescaler_b_halt = 1'b1;
		tick(2, 1'b1);
		chk("b_halt", 32'h1, o_count);
		i_prescaler_a_halt = 1'b0;
		i_prescaler_b_halt = 1'b0;
		i_prescaler_b_source = SRC_CASCADE;
		i_prescaler_b_divide = 3'h0;
		i_prescaler_a_divide = 3'h0;
		wr(WR_PRESCALER_A, 16'h0);
		wr(WR_PRESCALER_B, 16'h0);
		set_count(32'h0);
		tick(4, 1'b0);
		chk("casc_b", 32'h2, o_prescaler_stage_b);
		chk("casc_count", 32'h1, o_count);
		i_prescaler_a_halt = 1'b1;
		tick(4, 1'b0);
		chk("casc_a_halt", 32'h2, o_prescaler_stage_b);
		chk("casc_cnt_halt", 32'h1, o_count);
		$display("test prescale done");
	endtask : t_prescale

	task t_calendar;
		set_count(32'h5a5a_5a5a);
		i_prescaler_b_halt = 1'b1;
		i_prescaler_a_divide = 3'h1;
		i_calendar_select = 1'b1;
		step(2);
		chk("sec_init", 32'h0, o_seconds);
		chk("day_init", 32'h1, o_day_of_month);
		chk("mon_init", 32'h1, o_month);
		chk("ps_init", 32'h0, o_prescaler_stage_a);
		wr(WR_PRESCALER_A, 16'h0080);
		step(1);
		chk("valid_hi", 32'h1, o_time_read_valid);
		set_time(16'd2024, 8'd2, 8'd28, 8'd0, 8'd59, 8'd59);
		chk("sec_roll", 32'h0, o_seconds);
		chk("min_roll", 32'h0, o_minutes);
		chk("hour_up", 32'h1, o_hours);
		chk("valid_lo", 32'h0, o_time_read_valid);
		set_time(16'd2024, 8'd2, 8'd28, 8'd23, 8'd59, 8'd59);
		chk("leap_day", 32'd29, o_day_of_month);
		chk("dow_roll", 32'h1, o_day_of_week);
		set_time(16'd2023, 8'd2, 8'd28, 8'd23, 8'd59, 8'd59);
		chk("plain_month", 32'd3, o_month);
		chk("plain_day", 32'd1, o_day_of_month);
		chk("year_kept", 32'd2023, o_year);
		i_main_count_halt = 1'b1;
		set_time(16'd2023, 8'd5, 8'd5, 8'd5, 8'd5, 8'd5);
		chk("halt_sec", 32'h5, o_seconds);
		chk("halt_ps", 32'hff, o_prescaler_stage_a);
		i_main_count_halt = 1'b0;
		i_bcd_format_select = 1'b1;
		step(2);
		chk("bcd_clr", 32'h0, o_seconds);
		chk("bcd_day", 32'h1, o_day_of_month);
		chk("bcd_ps", 32'h0, o_prescaler_stage_b);
		set_time(16'h2024, 8'h01, 8'h01, 8'h09, 8'h59, 8'h59);
		chk("bcd_hour", 32'h10, o_hours);
		chk("bcd_min", 32'h0, o_minutes);
		set_time(16'h1999, 8'h12, 8'h31, 8'h23, 8'h59, 8'h59);
		chk("bcd_year", 32'h2000, o_year);
		chk("bcd_new_month", 32'h01, o_month);
		chk("bcd_new_day", 32'h01, o_day_of_month);
		i_calendar_select = 1'b0;
		i_prescaler_b_halt = 1'b0;
		step(2);
		chk("back_count", 32'h0, o_count);
		chk("back_ps_a", 32'h0, o_prescaler_stage_a);
		chk("back_ps_b", 32'h0, o_prescaler_stage_b);
		chk("cnt_valid", 32'h0, o_time_read_valid);
		$display("test calendar done");
	endtask : t_calendar

	task test_done;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done

	initial begin
		{i_nrst, i_aux_clk, i_subsystem_clock, i_calendar_select, i_bcd_format_select} = '0;
		{i_main_count_halt, i_prescaler_a_halt, i_prescaler_b_halt, i_wr_en} = '0;
		{i_prescaler_a_source, i_overflow_event_irq_enable, i_wr_sel, i_wr_data} = '0;
		{i_prescaler_b_source, i_counter_source_select, i_overflow_event_select} = '0;
		{i_prescaler_a_divide, i_prescaler_b_divide} = '0;
		step(6);
		i_nrst = 1'b1;
		step(1);
		t_reset();
		t_events();
		t_prescale();
		t_calendar();
		test_done();
	end
endmodule : test_ccc_top
`default_nettype wire
